// *** src/ccr_pkg.sv ***
// Package: register map, field layout and reset values of the channel calibration bank
package ccr_pkg;

  localparam int unsigned CCR_REG_W  = 16;
  localparam int unsigned CCR_ADDR_W = 8;
  localparam int unsigned CCR_IDX_W  = 6;
  localparam int unsigned CCR_WORD_W = 24;

  // Register indexes; byte address is four times the index
  localparam logic [5:0] CCR_IDX_CH1_CONFIG          = 6'h0E;
  localparam logic [5:0] CCR_IDX_CH1_OFFSET_CAL_HIGH = 6'h0F;
  localparam logic [5:0] CCR_IDX_CH1_OFFSET_CAL_LOW  = 6'h10;
  localparam logic [5:0] CCR_IDX_CH1_GAIN_CAL_HIGH   = 6'h11;
  localparam logic [5:0] CCR_IDX_CH1_GAIN_CAL_LOW    = 6'h12;
  localparam logic [5:0] CCR_IDX_CH2_CONFIG          = 6'h13;
  localparam logic [5:0] CCR_IDX_CH2_OFFSET_CAL_HIGH = 6'h14;
  localparam logic [5:0] CCR_IDX_CH2_OFFSET_CAL_LOW  = 6'h15;
  localparam logic [5:0] CCR_IDX_CH2_GAIN_CAL_HIGH   = 6'h16;
  localparam logic [5:0] CCR_IDX_CH2_GAIN_CAL_LOW    = 6'h17;
  localparam logic [5:0] CCR_IDX_CONVERTER_CONTROL   = 6'h31;

  // Values after reset
  localparam logic [15:0] CCR_RST_OFFSET_HIGH = 16'h0000;
  localparam logic [15:0] CCR_RST_GAIN_HIGH   = 16'h8000;
  localparam logic [7:0]  CCR_RST_LOW_FIELD   = 8'h00;
  localparam logic [15:0] CCR_RST_CONFIG      = 16'h0000;
  localparam logic [15:0] CCR_RST_CONV_CTRL   = 16'h0000;

  // Field positions
  localparam int unsigned CCR_LOW_MSB      = 15;
  localparam int unsigned CCR_LOW_LSB      = 8;
  localparam int unsigned CCR_PHASE_MSB    = 15;
  localparam int unsigned CCR_PHASE_LSB    = 6;
  localparam int unsigned CCR_TEMP_SENSOR_SOURCE_SELECT_BIT   = 5;
  localparam int unsigned CCR_TEMP_SENSOR_MEASURE_ENABLE_BIT    = 4;
  localparam int unsigned CCR_TS_SWAP_BIT  = 2;
  localparam int unsigned CCR_MUX_MSB      = 1;
  localparam int unsigned CCR_MUX_LSB      = 0;

  // Writable bits; the rest read as zero
  localparam logic [15:0] CCR_CH1_CONFIG_MASK = 16'hFFC3;
  localparam logic [15:0] CCR_CH2_CONFIG_MASK = 16'hFFF7;

  localparam logic [1:0]  CCR_RESP_OKAY   = 2'h0;
  localparam logic [1:0]  CCR_RESP_SLVERR = 2'h2;
  localparam logic [3:0]  CCR_STRB_WORD   = 4'h3;

  typedef enum logic [1:0] {
    CCR_IN_NORMAL,
    CCR_IN_SHORTED,
    CCR_IN_DC_DIAG,
    CCR_IN_AC_DIAG
  } ccr_input_sel_e;

endpackage : ccr_pkg

// *** src/ccr_cal_channel.sv ***
// One channel's offset and gain calibration registers
`timescale 1ns/1ps
`default_nettype none
module ccr_cal_channel (
  input  wire logic                 clock,
  input  wire logic                 nrst,
  input  wire logic [15:0]          wr_data,
  input  wire logic                 wr_offset_high,
  input  wire logic                 wr_offset_low,
  input  wire logic                 wr_gain_high,
  input  wire logic                 wr_gain_low,
  output logic      [15:0]          offset_high_val,
  output logic      [15:0]          offset_low_val,
  output logic      [15:0]          gain_high_val,
  output logic      [15:0]          gain_low_val,
  output logic signed [23:0]        offset_word,
  output logic      [23:0]          gain_word
);
  import ccr_pkg::*;

  logic [15:0] offset_high_reg, offset_high_next;
  logic [7:0]  offset_low_reg,  offset_low_next;
  logic [15:0] gain_high_reg,   gain_high_next;
  logic [7:0]  gain_low_reg,    gain_low_next;

  always_comb begin
    offset_high_next = wr_offset_high ? wr_data : offset_high_reg;
    offset_low_next  = wr_offset_low ? wr_data[CCR_LOW_MSB:CCR_LOW_LSB] : offset_low_reg;
    gain_high_next   = wr_gain_high ? wr_data : gain_high_reg;
    gain_low_next    = wr_gain_low ? wr_data[CCR_LOW_MSB:CCR_LOW_LSB] : gain_low_reg;
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      offset_high_reg <= CCR_RST_OFFSET_HIGH;
      offset_low_reg  <= CCR_RST_LOW_FIELD;
      gain_high_reg   <= CCR_RST_GAIN_HIGH;
      gain_low_reg    <= CCR_RST_LOW_FIELD;
    end else begin
      offset_high_reg <= offset_high_next;
      offset_low_reg  <= offset_low_next;
      gain_high_reg   <= gain_high_next;
      gain_low_reg    <= gain_low_next;
    end
  end

  // Low byte of each low register is not stored at all
  assign offset_high_val = offset_high_reg;
  assign offset_low_val  = {offset_low_reg, 8'h00};
  assign gain_high_val   = gain_high_reg;
  assign gain_low_val    = {gain_low_reg, 8'h00};
  assign offset_word     = {offset_high_reg, offset_low_reg};
  assign gain_word       = {gain_high_reg, gain_low_reg};

  ////////////////////////////////////////////////////////////////////////////
  property p_cal_reset;
    @(posedge clock) !nrst |=> gain_word == 24'h800000 && offset_word == 24'sh000000;
  endproperty
  a_cal_reset: assert property (p_cal_reset) else $error("calibration reset value wrong");

  property p_offset_assembly;
    @(posedge clock) disable iff (!nrst)
      wr_offset_high |=> offset_word[23:8] == $past(wr_data) && offset_word[7:0] == $past(offset_word[7:0]);
  endproperty
  a_offset_assembly: assert property (p_offset_assembly) else $error("offset high write misplaced");

  property p_gain_low_assembly;
    @(posedge clock) disable iff (!nrst)
      wr_gain_low && !wr_gain_high |=> gain_word[7:0] == $past(wr_data[15:8]) && gain_low_val[7:0] == 8'h00;
  endproperty
  a_gain_low_assembly: assert property (p_gain_low_assembly) else $error("gain low write misplaced");

endmodule : ccr_cal_channel
`default_nettype wire

// *** src/ccr_channel_cal_config_regs.sv ***
// Channel calibration and configuration register bank with an AXI4-Lite slave
//
// Summary of operation
// - Offset word: high reg plus low byte
// - Gain word unsigned, same assembly, below 2.0
// - Gain high resets to 8000h, unity gain
// - Offset registers and gain low reset zero
// - Ch2 config bits 15:6 signed phase delay
// - Ch2 config bit 5 picks sensor source
// - Ch2 config bit 4 enables sensor mode
// - Ch2 config bit 2 swaps sensor polarity
// - Ch2 config bits 1:0 pick input
// - Ch2 config resets to zero
// - Converter control at 31h, resets zero
// - Ch1 config bits 1:0 pick input
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module ccr_channel_cal_config_regs (
  input  wire logic                               clock,
  input  wire logic                               nrst,
  input  wire logic [ccr_pkg::CCR_ADDR_W-1:0]     s_axi_awaddr,
  input  wire logic                               s_axi_awvalid,
  output logic                                    s_axi_awready,
  input  wire logic [31:0]                        s_axi_wdata,
  input  wire logic [3:0]                         s_axi_wstrb,
  input  wire logic                               s_axi_wvalid,
  output logic                                    s_axi_wready,
  output logic [1:0]                              s_axi_bresp,
  output logic                                    s_axi_bvalid,
  input  wire logic                               s_axi_bready,
  input  wire logic [ccr_pkg::CCR_ADDR_W-1:0]     s_axi_araddr,
  input  wire logic                               s_axi_arvalid,
  output logic                                    s_axi_arready,
  output logic [31:0]                             s_axi_rdata,
  output logic [1:0]                              s_axi_rresp,
  output logic                                    s_axi_rvalid,
  input  wire logic                               s_axi_rready,
  output logic signed [ccr_pkg::CCR_WORD_W-1:0]   ch1_offset_word,
  output logic [ccr_pkg::CCR_WORD_W-1:0]          ch1_gain_word,
  output logic signed [ccr_pkg::CCR_WORD_W-1:0]   ch2_offset_word,
  output logic [ccr_pkg::CCR_WORD_W-1:0]          ch2_gain_word,
  output logic signed [9:0]                       ch1_phase_delay,
  output ccr_pkg::ccr_input_sel_e                 ch1_input_select,
  output logic signed [9:0]                       ch2_phase_delay,
  output logic                                    temp_sensor_source_select,
  output logic                                    temp_sensor_measure_enable,
  output logic                                    temp_sensor_polarity_swap,
  output ccr_pkg::ccr_input_sel_e                 ch2_input_select,
  output logic [15:0]                             converter_control
);
  import ccr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Write channel state
  logic                 aw_full_reg, aw_full_next;
  logic [CCR_IDX_W-1:0] aw_idx_reg,  aw_idx_next;
  logic                 w_full_reg,  w_full_next;
  logic [15:0]          wdata_reg,   wdata_next;
  logic [3:0]           wstrb_reg,   wstrb_next;
  logic                 awready_reg, awready_next;
  logic                 wready_reg,  wready_next;
  logic                 bvalid_reg,  bvalid_next;
  logic [1:0]           bresp_reg,   bresp_next;
  logic                 wr_go;
  logic                 wr_mapped;
  logic                 wr_en;

  // Read channel state
  logic                 arready_reg, arready_next;
  logic                 rvalid_reg,  rvalid_next;
  logic [1:0]           rresp_reg,   rresp_next;
  logic [15:0]          rdata_reg,   rdata_next;
  logic [CCR_IDX_W-1:0] rd_idx;
  logic [15:0]          rd_val;
  logic                 rd_mapped;

  // Configuration registers
  logic [15:0] ch1_config_reg, ch1_config_next;
  logic [15:0] ch2_config_reg, ch2_config_next;
  logic [15:0] conv_ctrl_reg,  conv_ctrl_next;

  // Calibration readback
  logic [15:0] c1_oh, c1_ol, c1_gh, c1_gl;
  logic [15:0] c2_oh, c2_ol, c2_gh, c2_gl;

  function automatic logic idx_mapped(input logic [CCR_IDX_W-1:0] idx);
    idx_mapped = (idx >= CCR_IDX_CH1_CONFIG && idx <= CCR_IDX_CH2_GAIN_CAL_LOW) ||
                 idx == CCR_IDX_CONVERTER_CONTROL;
  endfunction : idx_mapped

  ////////////////////////////////////////////////////////////////////////////
  // Write path: address and data in either order, response after both
  assign wr_go     = aw_full_reg && w_full_reg && !bvalid_reg;
  assign wr_mapped = idx_mapped(aw_idx_reg);
  // Partial strobes would split a 16-bit word, so they are refused
  assign wr_en     = wr_go && wr_mapped && (wstrb_reg & CCR_STRB_WORD) == CCR_STRB_WORD;

  always_comb begin
    aw_full_next = aw_full_reg;
    aw_idx_next  = aw_idx_reg;
    w_full_next  = w_full_reg;
    wdata_next   = wdata_reg;
    wstrb_next   = wstrb_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    if (s_axi_awvalid && awready_reg) begin
      aw_full_next = 1'b1;
      aw_idx_next  = s_axi_awaddr[CCR_ADDR_W-1:2];
    end
    if (s_axi_wvalid && wready_reg) begin
      w_full_next = 1'b1;
      wdata_next  = s_axi_wdata[15:0];
      wstrb_next  = s_axi_wstrb;
    end
    if (wr_go) begin
      aw_full_next = 1'b0;
      w_full_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = wr_en ? CCR_RESP_OKAY : CCR_RESP_SLVERR;
    end else if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    awready_next = !aw_full_next && !bvalid_next;
    wready_next  = !w_full_next && !bvalid_next;
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      aw_full_reg <= 1'b0;
      aw_idx_reg  <= '0;
      w_full_reg  <= 1'b0;
      wdata_reg   <= 16'h0000;
      wstrb_reg   <= 4'h0;
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= CCR_RESP_OKAY;
    end else begin
      aw_full_reg <= aw_full_next;
      aw_idx_reg  <= aw_idx_next;
      w_full_reg  <= w_full_next;
      wdata_reg   <= wdata_next;
      wstrb_reg   <= wstrb_next;
      awready_reg <= awready_next;
      wready_reg  <= wready_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration and converter control registers
  always_comb begin
    ch1_config_next = ch1_config_reg;
    ch2_config_next = ch2_config_reg;
    conv_ctrl_next  = conv_ctrl_reg;
    if (wr_en) begin
      case (aw_idx_reg)
        CCR_IDX_CH1_CONFIG:        ch1_config_next = wdata_reg & CCR_CH1_CONFIG_MASK;
        CCR_IDX_CH2_CONFIG:        ch2_config_next = wdata_reg & CCR_CH2_CONFIG_MASK;
        CCR_IDX_CONVERTER_CONTROL: conv_ctrl_next  = wdata_reg;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      ch1_config_reg <= CCR_RST_CONFIG;
      ch2_config_reg <= CCR_RST_CONFIG;
      conv_ctrl_reg  <= CCR_RST_CONV_CTRL;
    end else begin
      ch1_config_reg <= ch1_config_next;
      ch2_config_reg <= ch2_config_next;
      conv_ctrl_reg  <= conv_ctrl_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Calibration registers, one instance per channel
  ccr_cal_channel u_ch1 (
    .clock           (clock),
    .nrst            (nrst),
    .wr_data         (wdata_reg),
    .wr_offset_high  (wr_en && aw_idx_reg == CCR_IDX_CH1_OFFSET_CAL_HIGH),
    .wr_offset_low   (wr_en && aw_idx_reg == CCR_IDX_CH1_OFFSET_CAL_LOW),
    .wr_gain_high    (wr_en && aw_idx_reg == CCR_IDX_CH1_GAIN_CAL_HIGH),
    .wr_gain_low     (wr_en && aw_idx_reg == CCR_IDX_CH1_GAIN_CAL_LOW),
    .offset_high_val (c1_oh),
    .offset_low_val  (c1_ol),
    .gain_high_val   (c1_gh),
    .gain_low_val    (c1_gl),
    .offset_word     (ch1_offset_word),
    .gain_word       (ch1_gain_word)
  );

  ccr_cal_channel u_ch2 (
    .clock           (clock),
    .nrst            (nrst),
    .wr_data         (wdata_reg),
    .wr_offset_high  (wr_en && aw_idx_reg == CCR_IDX_CH2_OFFSET_CAL_HIGH),
    .wr_offset_low   (wr_en && aw_idx_reg == CCR_IDX_CH2_OFFSET_CAL_LOW),
    .wr_gain_high    (wr_en && aw_idx_reg == CCR_IDX_CH2_GAIN_CAL_HIGH),
    .wr_gain_low     (wr_en && aw_idx_reg == CCR_IDX_CH2_GAIN_CAL_LOW),
    .offset_high_val (c2_oh),
    .offset_low_val  (c2_ol),
    .gain_high_val   (c2_gh),
    .gain_low_val    (c2_gl),
    .offset_word     (ch2_offset_word),
    .gain_word       (ch2_gain_word)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Read path: one-cycle answer, data sampled at acceptance
  assign rd_idx    = s_axi_araddr[CCR_ADDR_W-1:2];
  assign rd_mapped = idx_mapped(rd_idx);

  always_comb begin
    case (rd_idx)
      CCR_IDX_CH1_CONFIG:          rd_val = ch1_config_reg;
      CCR_IDX_CH1_OFFSET_CAL_HIGH: rd_val = c1_oh;
      CCR_IDX_CH1_OFFSET_CAL_LOW:  rd_val = c1_ol;
      CCR_IDX_CH1_GAIN_CAL_HIGH:   rd_val = c1_gh;
      CCR_IDX_CH1_GAIN_CAL_LOW:    rd_val = c1_gl;
      CCR_IDX_CH2_CONFIG:          rd_val = ch2_config_reg;
      CCR_IDX_CH2_OFFSET_CAL_HIGH: rd_val = c2_oh;
      CCR_IDX_CH2_OFFSET_CAL_LOW:  rd_val = c2_ol;
      CCR_IDX_CH2_GAIN_CAL_HIGH:   rd_val = c2_gh;
      CCR_IDX_CH2_GAIN_CAL_LOW:    rd_val = c2_gl;
      CCR_IDX_CONVERTER_CONTROL:   rd_val = conv_ctrl_reg;
      default:                     rd_val = 16'h0000;
    endcase
  end

  always_comb begin
    rvalid_next = rvalid_reg;
    rresp_next  = rresp_reg;
    rdata_next  = rdata_reg;
    if (s_axi_arvalid && arready_reg) begin
      rvalid_next = 1'b1;
      rresp_next  = rd_mapped ? CCR_RESP_OKAY : CCR_RESP_SLVERR;
      rdata_next  = rd_val;
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
    arready_next = !rvalid_next;
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b0;
      rresp_reg   <= CCR_RESP_OKAY;
      rdata_reg   <= 16'h0000;
    end else begin
      arready_reg <= arready_next;
      rvalid_reg  <= rvalid_next;
      rresp_reg   <= rresp_next;
      rdata_reg   <= rdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign s_axi_awready              = awready_reg;
  assign s_axi_wready               = wready_reg;
  assign s_axi_bvalid               = bvalid_reg;
  assign s_axi_bresp                = bresp_reg;
  assign s_axi_arready              = arready_reg;
  assign s_axi_rvalid               = rvalid_reg;
  assign s_axi_rresp                = rresp_reg;
  assign s_axi_rdata                = {16'h0000, rdata_reg};
  assign ch1_phase_delay            = ch1_config_reg[CCR_PHASE_MSB:CCR_PHASE_LSB];
  assign ch1_input_select           = ccr_input_sel_e'(ch1_config_reg[CCR_MUX_MSB:CCR_MUX_LSB]);
  assign ch2_phase_delay            = ch2_config_reg[CCR_PHASE_MSB:CCR_PHASE_LSB];
  assign temp_sensor_source_select  = ch2_config_reg[CCR_TEMP_SENSOR_SOURCE_SELECT_BIT];
  assign temp_sensor_measure_enable = ch2_config_reg[CCR_TEMP_SENSOR_MEASURE_ENABLE_BIT];
  assign temp_sensor_polarity_swap  = ch2_config_reg[CCR_TS_SWAP_BIT];
  assign ch2_input_select           = ccr_input_sel_e'(ch2_config_reg[CCR_MUX_MSB:CCR_MUX_LSB]);
  assign converter_control          = conv_ctrl_reg;

  ////////////////////////////////////////////////////////////////////////////
  property p_ch2_fields;
    @(posedge clock) disable iff (!nrst)
      wr_en && aw_idx_reg == CCR_IDX_CH2_CONFIG |=>
        ch2_phase_delay == $past(wdata_reg[15:6]) && temp_sensor_source_select == $past(wdata_reg[5]) &&
        temp_sensor_measure_enable == $past(wdata_reg[4]) && temp_sensor_polarity_swap == $past(wdata_reg[2]) &&
        ch2_input_select == $past(wdata_reg[1:0]) && ch2_config_reg[3] == 1'b0;
  endproperty
  a_ch2_fields: assert property (p_ch2_fields) else $error("ch2 config fields wrong");

  property p_ch1_mux;
    @(posedge clock) disable iff (!nrst)
      wr_en && aw_idx_reg == CCR_IDX_CH1_CONFIG |=>
        ch1_input_select == $past(wdata_reg[1:0]) && ch1_config_reg[5:2] == 4'h0;
  endproperty
  a_ch1_mux: assert property (p_ch1_mux) else $error("ch1 input select wrong");

  property p_config_reset;
    @(posedge clock) !nrst |=> ch2_config_reg == 16'h0000 && converter_control == 16'h0000 &&
      ch2_input_select == CCR_IN_NORMAL && !temp_sensor_measure_enable;
  endproperty
  a_config_reset: assert property (p_config_reset) else $error("config reset value wrong");

  property p_conv_ctrl_write;
    @(posedge clock) disable iff (!nrst)
      wr_en && aw_idx_reg == CCR_IDX_CONVERTER_CONTROL |=> converter_control == $past(wdata_reg);
  endproperty
  a_conv_ctrl_write: assert property (p_conv_ctrl_write) else $error("converter control not written");

  property p_partial_refused;
    @(posedge clock) disable iff (!nrst)
      wr_go && wstrb_reg[1:0] != 2'h3 |=> s_axi_bvalid && s_axi_bresp == CCR_RESP_SLVERR &&
        $stable(ch2_config_reg) && $stable(conv_ctrl_reg);
  endproperty
  a_partial_refused: assert property (p_partial_refused) else $error("partial write not refused");

  property p_low_reserved_read;
    @(posedge clock) disable iff (!nrst)
      s_axi_arvalid && s_axi_arready && (rd_idx == CCR_IDX_CH1_GAIN_CAL_LOW || rd_idx == CCR_IDX_CH2_OFFSET_CAL_LOW)
        |=> s_axi_rvalid && s_axi_rdata[7:0] == 8'h00 && s_axi_rresp == CCR_RESP_OKAY;
  endproperty
  a_low_reserved_read: assert property (p_low_reserved_read) else $error("reserved bits read nonzero");

  property p_unmapped_read;
    @(posedge clock) disable iff (!nrst)
      s_axi_arvalid && s_axi_arready && !rd_mapped |=> s_axi_rresp == CCR_RESP_SLVERR && s_axi_rdata == 32'h0;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not an error");

  property p_response_hold;
    @(posedge clock) disable iff (!nrst)
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp);
  endproperty
  a_response_hold: assert property (p_response_hold) else $error("read answer dropped before taken");

  property p_write_answer;
    @(posedge clock) disable iff (!nrst)
      aw_full_reg && w_full_reg && !bvalid_reg |=> s_axi_bvalid ##0 !s_axi_awready [*1];
  endproperty
  a_write_answer: assert property (p_write_answer) else $error("write answer not one cycle later");

  c_ch2_write:   cover property (@(posedge clock) disable iff (!nrst) wr_en && aw_idx_reg == CCR_IDX_CH2_CONFIG);
  c_gain_write:  cover property (@(posedge clock) disable iff (!nrst) wr_en && aw_idx_reg == CCR_IDX_CH1_GAIN_CAL_HIGH);
  c_slverr:      cover property (@(posedge clock) disable iff (!nrst) s_axi_bvalid && s_axi_bresp == CCR_RESP_SLVERR);
  c_read_stall:  cover property (@(posedge clock) disable iff (!nrst) s_axi_rvalid && !s_axi_rready);

endmodule : ccr_channel_cal_config_regs
`default_nettype wire

// *** tb/ccr_channel_cal_config_regs_tb.sv ***
// Self-checking bench for the calibration and configuration register bank
`timescale 1ns/1ps
`default_nettype none
module ccr_channel_cal_config_regs_tb;
  import ccr_pkg::*;
  logic clock = 0, nrst = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'h0;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic signed [23:0] ch1_offset_word, ch2_offset_word;
  logic [23:0] ch1_gain_word, ch2_gain_word;
  logic signed [9:0] ch1_phase_delay, ch2_phase_delay;
  logic temp_sensor_source_select, temp_sensor_measure_enable, temp_sensor_polarity_swap;
  ccr_input_sel_e ch1_input_select, ch2_input_select;
  logic [15:0] converter_control;
  int err_total = 0, comparisons = 0, cycles = 0;
  // Index, writable mask and reset value of every mapped register
  logic [5:0]  ix [11] = '{6'h0E, 6'h0F, 6'h10, 6'h11, 6'h12, 6'h13, 6'h14, 6'h15, 6'h16, 6'h17, 6'h31};
  logic [15:0] mk [11] = '{16'hFFC3, 16'hFFFF, 16'hFF00, 16'hFFFF, 16'hFF00, 16'hFFF7,
                           16'hFFFF, 16'hFF00, 16'hFFFF, 16'hFF00, 16'hFFFF};
  logic [15:0] rv [11] = '{16'h0, 16'h0, 16'h0, 16'h8000, 16'h0, 16'h0, 16'h0, 16'h0, 16'h8000, 16'h0, 16'h0};

  ccr_channel_cal_config_regs i_dut (.*);

  always #20 clock = ~clock;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish
  // Generous ceiling; the sequence needs well under a thousand cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Offers address and data together; releases each when taken
  task automatic wr(input logic [5:0] idx, input logic [15:0] d, input logic [3:0] st, input logic [1:0] er);
    logic aw_done, w_done, b_done;
    aw_done = 0; w_done = 0; b_done = 0;
    @(posedge clock);
    s_axi_awaddr <= {idx, 2'b00}; s_axi_awvalid <= 1; s_axi_wdata <= {16'hA5A5, d};
    s_axi_wstrb <= st; s_axi_wvalid <= 1; s_axi_bready <= 1;
    while (!b_done) begin
      @(posedge clock);
      if (!aw_done && s_axi_awready === 1'b1) begin aw_done = 1; s_axi_awvalid <= 0; end
      if (!w_done && s_axi_wready === 1'b1) begin w_done = 1; s_axi_wvalid <= 0; end
      if (s_axi_bvalid === 1'b1) begin b_done = 1; s_axi_bready <= 0; chk({30'h0, s_axi_bresp}, {30'h0, er}); end
    end
  endtask : wr
  task automatic rd(input logic [5:0] idx, input logic [15:0] e, input logic [1:0] er);
    logic r_done;
    r_done = 0;
    @(posedge clock);
    s_axi_araddr <= {idx, 2'b00}; s_axi_arvalid <= 1; s_axi_rready <= 1;
    while (!r_done) begin
      @(posedge clock);
      if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 0;
      if (s_axi_rvalid === 1'b1) begin
        r_done = 1; s_axi_rready <= 0;
        chk(s_axi_rdata, {16'h0, e});
        chk({30'h0, s_axi_rresp}, {30'h0, er});
      end
    end
  endtask : rd
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [1:0] k2;
    logic [15:0] d;
    repeat (16) @(posedge clock);
    nrst <= 1;
    repeat (2) @(posedge clock);
    for (int i = 0; i < 11; i++) rd(ix[i], rv[i], CCR_RESP_OKAY);
    chk({8'h0, ch1_gain_word}, 32'h800000);
    chk({8'h0, ch2_offset_word}, 32'h0);
    // Reserved bits written as ones must stay zero
    for (int i = 0; i < 11; i++) wr(ix[i], 16'hFFFF, 4'hF, CCR_RESP_OKAY);
    for (int i = 0; i < 11; i++) rd(ix[i], mk[i], CCR_RESP_OKAY);
    chk({16'h0, converter_control}, 32'h0000FFFF);
    wr(6'h0F, 16'h8001, CCR_STRB_WORD, CCR_RESP_OKAY);
    wr(6'h10, 16'h12AB, CCR_STRB_WORD, CCR_RESP_OKAY);
    chk({8'h0, ch1_offset_word}, 32'h00800112);
    wr(6'h16, 16'h7FFF, CCR_STRB_WORD, CCR_RESP_OKAY);
    wr(6'h17, 16'hC3FF, CCR_STRB_WORD, CCR_RESP_OKAY);
    chk({8'h0, ch2_gain_word}, 32'h007FFFC3);
    chk({8'h0, ch1_gain_word}, 32'h00FFFFFF);
    for (int k = 0; k < 4; k++) begin
      k2 = k[1:0];
      d = {10'h200 | 10'(k), k2[0], k2[1], 1'b1, k2[0], k2};
      wr(6'h13, d, 4'hF, CCR_RESP_OKAY);
      chk({22'h0, ch2_phase_delay}, {22'h0, 10'h200 | 10'(k)});
      chk({31'h0, temp_sensor_source_select}, {31'h0, k2[0]});
      chk({31'h0, temp_sensor_measure_enable}, {31'h0, k2[1]});
      chk({31'h0, temp_sensor_polarity_swap}, {31'h0, k2[0]});
      chk({30'h0, ch2_input_select}, {30'h0, k2});
      rd(6'h13, d & 16'hFFF7, CCR_RESP_OKAY);
      wr(6'h0E, {10'h155, 4'hF, k2}, 4'hF, CCR_RESP_OKAY);
      chk({30'h0, ch1_input_select}, {30'h0, k2});
      chk({22'h0, ch1_phase_delay}, {22'h0, 10'h155});
    end
    // Refusals: unmapped place and partial strobe leave contents alone
    wr(6'h20, 16'h1234, 4'hF, CCR_RESP_SLVERR);
    rd(6'h20, 16'h0, CCR_RESP_SLVERR);
    wr(6'h11, 16'h0001, 4'h1, CCR_RESP_SLVERR);
    rd(6'h11, 16'hFFFF, CCR_RESP_OKAY);
    tally_and_finish();
  end
endmodule : ccr_channel_cal_config_regs_tb
`default_nettype wire
